// [adr_pkg.sv]
// package of register offsets, field positions, reset values and delay figures
// assumes a 16-bit register file reached over a 32-bit avalon-mm slave
package adr_pkg;
  // ==========================================================================
  // register map (printed offsets are indices, byte address is four times)
  localparam logic [3:0]  ADR_IDX_COARSE   = 4'hc;   // coarse delay register index
  localparam logic [3:0]  ADR_IDX_FINE     = 4'hd;   // fine delay register index
  localparam logic [3:0]  ADR_IDX_STATUS   = 4'he;   // applied delay status index
  localparam logic [5:0]  ADR_ADDR_COARSE  = {ADR_IDX_COARSE, 2'h0};
  localparam logic [5:0]  ADR_ADDR_FINE    = {ADR_IDX_FINE, 2'h0};
  localparam logic [5:0]  ADR_ADDR_STATUS  = {ADR_IDX_STATUS, 2'h0};
  // ==========================================================================
  // reset values
  localparam logic [15:0] ADR_COARSE_RESET = 16'h0004;  // stabilizer on
  localparam logic [15:0] ADR_FINE_RESET   = 16'h0000;
  // ==========================================================================
  // field positions
  localparam int ADR_CAM_LSB   = 4;    // coarse magnitude 15:4
  localparam int ADR_CSEL_BIT  = 3;    // coarse-register select
  localparam int ADR_DCS_BIT   = 2;    // duty-cycle stabilizer
  localparam int ADR_FAM_LSB   = 10;   // fine magnitude 15:10
  localparam int ADR_FSEL_BIT  = 8;    // fine-register select
  // writable bit masks; reserved bits read as zero
  localparam logic [15:0] ADR_COARSE_MASK = 16'hfffc;
  localparam logic [15:0] ADR_FINE_MASK   = 16'hfd00;
  // ==========================================================================
  // delay figures
  localparam logic [11:0] ADR_CAM_MAX     = 12'h97f;  // 2431d, top code
  localparam int          ADR_CAM_MAX_PS  = 825;      // delay at top code, ps
  localparam int          ADR_FAM_MAX_FS  = 2300;     // fine delay at 63d, fs
  localparam int          ADR_BUS_WAIT    = 1;        // waitrequest cycles per access
endpackage

// [adr_regs.sv]
// aperture delay register bank with avalon-mm slave
// assumes the analog delay line consumes the delay code outputs
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module adr_regs
  import adr_pkg::*;
#(
  parameter int CAM_W = 12,  // coarse magnitude width
  parameter int FAM_W = 6    // fine magnitude width
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clock_enable,
  // avalon-mm slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // delay line control
  output logic      [11:0] coarse_delay_code,
  output logic      [5:0]  fine_delay_code,
  output logic             delay_adjust_on,
  output logic             duty_cycle_stabilizer_on
);
  // ==========================================================================
  // elaboration checks
  if (CAM_W != 12 || FAM_W != 6) begin : g_bad
    $error("adr_regs: field widths fixed by the register layout");
  end

  // ==========================================================================
  // storage
  logic [15:0] clock_delay_coarse;       // coarse register
  logic [15:0] clock_delay_fine;         // fine register
  logic [15:0] next_clock_delay_coarse;
  logic [15:0] next_clock_delay_fine;
  logic        busy;                     // access accepted, answer next edge
  logic        next_busy;
  logic [31:0] next_readdata;
  logic        next_waitrequest;
  logic [11:0] next_coarse_delay_code;
  logic [5:0]  next_fine_delay_code;
  logic        next_delay_adjust_on;
  logic        next_dcs_on;
  logic [11:0] cam_clamped;              // saturated coarse code
  logic [15:0] wmask;                    // byte-enable mask for low half
  logic        coarse_sel;               // coarse-register select
  logic        fine_sel;                 // fine-register select

  // field views
  assign coarse_sel = next_clock_delay_coarse[ADR_CSEL_BIT];
  assign fine_sel   = next_clock_delay_fine[ADR_FSEL_BIT];
  assign wmask      = {{8{byteenable[1]}}, {8{byteenable[0]}}};

  // saturating clamp on the coarse code
  adr_sat #(
    .WIDTH(12)
  ) u_sat (
    .code_in  (next_clock_delay_coarse[ADR_CAM_LSB +: 12]),
    .limit    (ADR_CAM_MAX),
    .code_out (cam_clamped)
  );

  // ==========================================================================
  // bus and register next state
  // one wait cycle: waitrequest high on the request edge, low the next
  always_comb begin
    next_clock_delay_coarse = clock_delay_coarse;
    next_clock_delay_fine   = clock_delay_fine;
    next_busy               = 1'b0;
    next_readdata           = readdata;
    next_waitrequest        = 1'b1;
    if ((read || write) && !busy) begin
      // first cycle of request: finish next edge
      next_busy        = 1'b1;
      next_waitrequest = 1'b0;
      if (write) begin
        unique case (address)
          ADR_ADDR_COARSE: next_clock_delay_coarse =
              (clock_delay_coarse & ~wmask) | (writedata[15:0] & wmask & ADR_COARSE_MASK);
          ADR_ADDR_FINE:   next_clock_delay_fine =
              (clock_delay_fine & ~wmask) | (writedata[15:0] & wmask & ADR_FINE_MASK);
          default: ;  // unmapped or read-only writes ignored
        endcase
      end else begin
        unique case (address)
          ADR_ADDR_COARSE: next_readdata = {16'h0000, clock_delay_coarse};
          ADR_ADDR_FINE:   next_readdata = {16'h0000, clock_delay_fine};
          ADR_ADDR_STATUS: next_readdata = {16'h0000, delay_adjust_on, 3'h0,
                                            coarse_delay_code};
          default:         next_readdata = 32'h0000_0000;  // unmapped reads zero
        endcase
      end
    end
  end

  // ==========================================================================
  // delay outputs, derived from the registers after this edge
  always_comb begin
    next_delay_adjust_on   = coarse_sel | fine_sel;
    next_coarse_delay_code = next_delay_adjust_on ? cam_clamped : 12'h000;
    next_fine_delay_code   = next_delay_adjust_on ?
                             next_clock_delay_fine[ADR_FAM_LSB +: 6] : 6'h00;
    next_dcs_on            = next_clock_delay_coarse[ADR_DCS_BIT];
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clock) begin
    if (reset) begin
      clock_delay_coarse       <= ADR_COARSE_RESET;
      clock_delay_fine         <= ADR_FINE_RESET;
      busy                     <= 1'b0;
      readdata                 <= 32'h0000_0000;
      waitrequest              <= 1'b1;
      coarse_delay_code        <= 12'h000;
      fine_delay_code          <= 6'h00;
      delay_adjust_on          <= 1'b0;
      duty_cycle_stabilizer_on <= 1'b1;
    end else if (clock_enable) begin
      clock_delay_coarse       <= next_clock_delay_coarse;
      clock_delay_fine         <= next_clock_delay_fine;
      busy                     <= next_busy;
      readdata                 <= next_readdata;
      waitrequest              <= next_waitrequest;
      coarse_delay_code        <= next_coarse_delay_code;
      fine_delay_code          <= next_fine_delay_code;
      delay_adjust_on          <= next_delay_adjust_on;
      duty_cycle_stabilizer_on <= next_dcs_on;
    end
  end

  // ==========================================================================
  // assertions
  // every check runs on the one clock and rests while reset is high
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // the coarse code handed to the delay line never passes the top code
  property p_sat;
    delay_adjust_on |-> coarse_delay_code <= ADR_CAM_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("coarse code above saturation");

  property p_coarse;
    delay_adjust_on && clock_delay_coarse[15:4] <= ADR_CAM_MAX
      |-> coarse_delay_code == clock_delay_coarse[15:4];
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse code not applied");

  property p_sat_top;
    delay_adjust_on && clock_delay_coarse[15:4] > ADR_CAM_MAX
      |-> coarse_delay_code == ADR_CAM_MAX;
  endproperty
  a_sat_top: assert property (p_sat_top) else $error("saturation not held");

  property p_enable;
    delay_adjust_on == (clock_delay_coarse[3] | clock_delay_fine[8]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable not from selects");

  property p_off;
    !delay_adjust_on |-> coarse_delay_code == 12'h000 && fine_delay_code == 6'h00;
  endproperty
  a_off: assert property (p_off) else $error("delay applied while off");

  property p_fine;
    delay_adjust_on |-> fine_delay_code == clock_delay_fine[15:10];
  endproperty
  a_fine: assert property (p_fine) else $error("fine code not applied");

  property p_fsel;
    clock_delay_fine[8] |-> delay_adjust_on;
  endproperty
  a_fsel: assert property (p_fsel) else $error("fine select ignored");

  property p_dcs;
    duty_cycle_stabilizer_on == clock_delay_coarse[2];
  endproperty
  a_dcs: assert property (p_dcs) else $error("stabilizer not from bit");

  // the answer lasts one cycle, so a held request is not taken twice
  // while the master is still releasing it
  property p_wait;
    (read || write) && waitrequest && clock_enable ##1 clock_enable |=> waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest pulse too long");

  // a taken request is answered on the very next cycle
  property p_answer;
    (read || write) && waitrequest && clock_enable |=> !waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered in one cycle");

  // a low clock enable freezes every register, the bus answer included,
  // so a standing request simply waits for the enable to return
  property p_freeze;
    !clock_enable |=> $stable(clock_delay_coarse) && $stable(clock_delay_fine) &&
                      $stable(waitrequest) && $stable(readdata) && $stable(coarse_delay_code);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

  // read data hold their word until the next taken read
  property p_rdhold;
    !(read && waitrequest && clock_enable) |=> $stable(readdata);
  endproperty
  a_rdhold: assert property (p_rdhold) else $error("read data changed without a read");

  // scenarios the bench should reach
  c_write: cover property (write && !waitrequest && address == ADR_ADDR_COARSE);
  c_read:  cover property (read && !waitrequest && address == ADR_ADDR_FINE);
  c_satc:  cover property (delay_adjust_on && coarse_delay_code == ADR_CAM_MAX);
  c_fine:  cover property (fine_delay_code == 6'h3f);
  c_frozen: cover property (!clock_enable && (read || write));
endmodule

// [adr_regs_tb_top.sv]
// self-checking bench for the aperture delay register bank
// assumes adr_regs and adr_pkg are compiled first; one 40 MHz clock
`timescale 1ns/1ps
module adr_regs_tb_top
  import adr_pkg::*;
;
  // ==========================================================================
  // stimulus and observed signals
  logic        clock        = 1'b0;  // 40 MHz
  logic        reset        = 1'b1;  // synchronous, active high
  logic        clock_enable = 1'b1;  // state advances
  logic [5:0]  address      = 6'h00;
  logic        read         = 1'b0;
  logic        write        = 1'b0;
  logic [31:0] writedata    = 32'h0;
  logic [3:0]  byteenable   = 4'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [11:0] coarse_delay_code;
  logic [5:0]  fine_delay_code;
  logic        delay_adjust_on;
  logic        duty_cycle_stabilizer_on;
  int          err_count    = 0;     // mismatches
  int          total_checks = 0;     // comparisons made
  int          cycles       = 0;     // timeout counter
  logic [31:0] rd;                   // last read word
  logic [3:0]  be_sel       = 4'h3;  // byte lanes used by the next access
  adr_regs adr_regs_inst (
    .clock(clock), .reset(reset), .clock_enable(clock_enable),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .coarse_delay_code(coarse_delay_code), .fine_delay_code(fine_delay_code),
    .delay_adjust_on(delay_adjust_on),
    .duty_cycle_stabilizer_on(duty_cycle_stabilizer_on)
  );
  // ==========================================================================
  // clock generation and hang guard
  initial begin
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count = err_count + 1;
      report_and_stop();
    end
  end
  // ==========================================================================
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // compare one value, four-state exact
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      err_count = err_count + 1;
    end
  endtask
  // ==========================================================================
  // avalon-mm accesses: hold request until waitrequest sampled low
  task automatic bus_access(input logic wr, input logic [5:0] a, input logic [15:0] d);
    @(posedge clock);
    address    <= a;
    read       <= ~wr;
    write      <= wr;
    writedata  <= {16'h0, d};
    byteenable <= be_sel;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    #1;
  endtask
  // read one register and compare its word
  task automatic read_check(input string what, input logic [5:0] a, input logic [31:0] exp);
    bus_access(1'b0, a, 16'h0);
    check(what, exp, rd);
  endtask
  // compare the delay line controls
  task automatic outs(input logic [11:0] c, input logic [5:0] f, input logic on, input logic dcs);
    check("coarse_delay_code", {20'h0, c}, {20'h0, coarse_delay_code});
    check("fine_delay_code", {26'h0, f}, {26'h0, fine_delay_code});
    check("delay_adjust_on", {31'h0, on}, {31'h0, delay_adjust_on});
    check("duty_cycle_stabilizer_on", {31'h0, dcs}, {31'h0, duty_cycle_stabilizer_on});
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    check("waitrequest reset", 32'h1, {31'h0, waitrequest});
    check("readdata reset", 32'h0, readdata);
    outs(12'h0, 6'h0, 1'b0, 1'b1);
    read_check("coarse reset", ADR_ADDR_COARSE, 32'h0004);
    read_check("fine reset", ADR_ADDR_FINE, 32'h0000);
    // top code with coarse select, reserved bits written as ones
    bus_access(1'b1, ADR_ADDR_COARSE, 16'h97fb);
    outs(12'h97f, 6'h0, 1'b1, 1'b0);
    read_check("coarse word", ADR_ADDR_COARSE, 32'h97f8);
    // first saturating code and full scale both clamp
    bus_access(1'b1, ADR_ADDR_COARSE, 16'h980c);
    outs(12'h97f, 6'h0, 1'b1, 1'b1);
    bus_access(1'b1, ADR_ADDR_COARSE, 16'hfffc);
    outs(12'h97f, 6'h0, 1'b1, 1'b1);
    read_check("coarse saturated word", ADR_ADDR_COARSE, 32'hfffc);
    read_check("status saturated", ADR_ADDR_STATUS, 32'h897f);
    bus_access(1'b1, ADR_ADDR_STATUS, 16'h0000);
    read_check("status read-only", ADR_ADDR_STATUS, 32'h897f);
    // coarse select off, fine select alone enables both fields
    bus_access(1'b1, ADR_ADDR_COARSE, 16'h0014);
    outs(12'h0, 6'h0, 1'b0, 1'b1);
    bus_access(1'b1, ADR_ADDR_FINE, 16'hffff);
    outs(12'h001, 6'h3f, 1'b1, 1'b1);
    read_check("fine word", ADR_ADDR_FINE, 32'hfd00);
    read_check("status fine select", ADR_ADDR_STATUS, 32'h8001);
    bus_access(1'b1, ADR_ADDR_FINE, 16'h0500);
    outs(12'h001, 6'h01, 1'b1, 1'b1);
    // both selects clear: no adjustment even with magnitudes set
    bus_access(1'b1, ADR_ADDR_FINE, 16'hfc00);
    outs(12'h0, 6'h0, 1'b0, 1'b1);
    // unmapped address reads zero and ignores writes
    bus_access(1'b1, 6'h20, 16'hffff);
    read_check("unmapped", 6'h20, 32'h0);
    outs(12'h0, 6'h0, 1'b0, 1'b1);
    // low clock enable: a standing write waits and nothing moves until it rises
    @(posedge clock);
    clock_enable <= 1'b0;
    address      <= ADR_ADDR_COARSE;
    write        <= 1'b1;
    writedata    <= 32'h0000_0018;
    byteenable   <= 4'h3;
    repeat (3) @(posedge clock);
    #1;
    check("frozen waitrequest", 32'h1, {31'h0, waitrequest});
    outs(12'h0, 6'h0, 1'b0, 1'b1);
    @(posedge clock);
    clock_enable <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    write <= 1'b0;
    #1;
    outs(12'h001, 6'h3f, 1'b1, 1'b0);
    // reset again in mid-run: every register returns to its reset word
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    check("waitrequest after reset", 32'h1, {31'h0, waitrequest});
    outs(12'h0, 6'h0, 1'b0, 1'b1);
    read_check("coarse after reset", ADR_ADDR_COARSE, 32'h0004);
    read_check("fine after reset", ADR_ADDR_FINE, 32'h0000);
    // byte lanes: only the enabled byte of the coarse word changes
    be_sel = 4'h2;
    bus_access(1'b1, ADR_ADDR_COARSE, 16'hab3f);
    outs(12'h0, 6'h0, 1'b0, 1'b1);
    read_check("coarse high lane", ADR_ADDR_COARSE, 32'hab04);
    be_sel = 4'h1;
    bus_access(1'b1, ADR_ADDR_COARSE, 16'h00ff);
    outs(12'h97f, 6'h0, 1'b1, 1'b1);
    read_check("coarse low lane", ADR_ADDR_COARSE, 32'habfc);
    be_sel = 4'h3;
    report_and_stop();
  end
endmodule

// [adr_sat.sv]
// saturating clamp for the coarse delay code
// assumes a pure combinational use by the register bank
`timescale 1ns/1ps
module adr_sat
  import adr_pkg::*;
#(
  parameter int WIDTH = 12
) (
  // code in and limit
  input  wire logic [WIDTH-1:0] code_in,
  input  wire logic [WIDTH-1:0] limit,
  // clamped code
  output logic      [WIDTH-1:0] code_out
);
  // ==========================================================================
  // clamp
  // codes above the limit hold the limit
  always_comb begin
    code_out = (code_in > limit) ? limit : code_in;
  end
endmodule
